/* inc/cph_pkg.sv */
// Shared constants, carriers and helpers for the cell PHY host interface.
// Assumes the including design compiles this package before any module.
package cph_pkg;

   // ----------------------------------------------------------------
   // Cell and buffer geometry
   // ----------------------------------------------------------------
   localparam logic [7:0] CELL_BYTES   = 8'h35;     // 53 bytes per cell.
   localparam logic [5:0] CELL_LAST    = 6'h34;     // Index of the last byte.
   localparam logic [7:0] FIFO_CAP     = 8'h6a;     // Two whole cells.
   localparam int         FIFO_AW      = 7;         // 128 slots hold the two cells.
   localparam logic [7:0] TX_MARGIN    = 8'h04;     // Writes still taken after full.
   localparam logic [7:0] RX_MARGIN    = 8'h04;     // Early drop of cell available.

   // ----------------------------------------------------------------
   // Register offsets, fields and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_STAT    = 8'h01;
   localparam logic [7:0] ADDR_DIAG    = 8'h02;
   localparam int         CTRL_INT_EN  = 0;
   localparam int         CTRL_CELL    = 1;
   localparam int         CTRL_ERR_ONLY = 5;
   localparam int         DIAG_RX_EARLY = 6;
   localparam int         DIAG_TX_HOLD = 7;
   localparam int         ST_SYMBOL    = 0;
   localparam int         ST_HEC       = 1;
   localparam int         ST_SHORT     = 2;
   localparam int         ST_RX_OVR    = 3;
   localparam int         ST_TX_PAR    = 4;
   localparam int         ST_LINE      = 5;
   localparam logic [7:0] ST_ERR_MASK  = 8'h07;     // Receive cell errors only.
   localparam logic [7:0] CTRL_RST     = 8'h00;
   localparam logic [7:0] DIAG_RST     = 8'h00;
   localparam logic [7:0] STAT_RST     = 8'h00;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       parity;
      logic       soc;
      logic [7:0] data;
   } cph_byte_t;

   typedef struct packed {
      logic       ale;
      logic       cs_n;
      logic       read_strobe_n;
      logic       write_strobe_n;
      logic [7:0] ad;
   } cph_ubus_t;

   typedef struct packed {
      logic symbol_err;
      logic hec_err;
      logic short_cell;
      logic line_change;
   } cph_evt_t;

   // Odd parity bit over one data byte.
   function automatic logic odd_par(input logic [7:0] d);
      return ~^d;
   endfunction : odd_par

endpackage : cph_pkg

/* verification/cph_host_if_bench.sv */
// Self-checking bench for cph_host_if against a queue model.
// Assumes cph_sar_model plays the host on every link and bus pin.
`timescale 1ns/100ps
module cph_host_if_bench;
   import cph_pkg::*;
   logic clk, reset, ad_oe, int_n, tx_clk, rx_clk, tx_enb_n, tx_full_clav;
   logic txq_valid, txq_ready, rx_enb_n, rx_empty_clav, rx_oe;
   logic rxq_soc, rxq_valid, rxq_ready;
   logic [7:0] ad_out, rxq_data, rd_val;
   cph_ubus_t ubus, bus_h;
   cph_evt_t evt;
   cph_byte_t tx_byte, txq_byte, rx_byte, b;
   cph_byte_t tx_exp[$], tx_got[$], rx_exp[$], rx_got[$];
   int bad_count, n_checks;

   // The shared pin shows the device while it drives, else the host.
   assign ubus = {bus_h[11:8], ad_oe ? ad_out : bus_h.ad};

   cph_host_if dut_u (.clk(clk), .reset(reset), .ubus(ubus), .ad_out(ad_out),
      .ad_oe(ad_oe), .int_n(int_n), .evt(evt), .tx_clk(tx_clk), .tx_enb_n(tx_enb_n),
      .tx_byte(tx_byte), .tx_full_clav(tx_full_clav), .txq_byte(txq_byte),
      .txq_valid(txq_valid), .txq_ready(txq_ready), .rx_clk(rx_clk),
      .rx_enb_n(rx_enb_n), .rx_byte(rx_byte), .rx_empty_clav(rx_empty_clav),
      .rx_oe(rx_oe), .rxq_soc(rxq_soc), .rxq_data(rxq_data),
      .rxq_valid(rxq_valid), .rxq_ready(rxq_ready));
   cph_sar_model sar_u (.clk(clk), .tx_full_clav(tx_full_clav), .ad_out(ubus.ad),
      .tx_clk(tx_clk), .rx_clk(rx_clk), .tx_enb_n(tx_enb_n), .tx_byte(tx_byte),
      .rx_enb_n(rx_enb_n), .bus_h(bus_h));

   initial clk = 1'b0;
   always #2 clk = ~clk;

   // Core drain stalls at random; both sides' bytes are collected.
   always @(negedge clk) txq_ready <= 1'($urandom_range(1));
   always @(posedge clk) if (txq_valid && txq_ready) tx_got.push_back(txq_byte);
   always @(negedge rx_clk)
      if (rx_empty_clav === 1'b1 && rx_oe === 1'b1) rx_got.push_back(rx_byte);

   task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk_reg

   task automatic chk_byte(input cph_byte_t g, input cph_byte_t e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk_byte

   // One cause pulse, then time for the interrupt pin to settle.
   task automatic pulse(input cph_evt_t e);
      @(negedge clk) evt = e;
      @(negedge clk) evt = '0;
      repeat (4) @(negedge clk);
   endtask : pulse

   task automatic close_out;
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out

   initial begin
      #100000;
      bad_count++;
      close_out;
   end

   initial begin
      void'($urandom(32'hfb91));
      {reset, evt, rxq_valid, rxq_soc, rxq_data} = {1'b1, 14'h0};
      repeat (12) @(negedge clk);
      reset = 1'b0;
      repeat (10) @(negedge clk);
      sar_u.reg_wr(ADDR_CTRL, 8'h01);
      pulse(4'b0100);
      chk_reg(8'(int_n), 8'h00);
      sar_u.reg_rd(ADDR_STAT, rd_val);
      chk_reg(rd_val, 8'h02);
      chk_reg(8'(int_n), 8'h01);
      sar_u.reg_wr(ADDR_CTRL, 8'h21);
      pulse(4'b0001);
      chk_reg(8'(int_n), 8'h01);
      pulse(4'b0010);
      chk_reg(8'(int_n), 8'h00);
      sar_u.reg_rd(ADDR_STAT, rd_val);
      chk_reg(rd_val, 8'h24);
      sar_u.reg_wr(ADDR_CTRL, 8'h00);
      pulse(4'b1000);
      chk_reg(8'(int_n), 8'h01);
      sar_u.reg_rd(8'h07, rd_val);
      chk_reg(rd_val, 8'h00);
      // Random cell, odd parity, start flag on byte 0 only.
      for (int i = 0; i < 53; i++) begin
         b.data = 8'($urandom);
         b.soc = (i == 0);
         b.parity = ~^b.data;
         tx_exp.push_back(b);
      end
      sar_u.send_cell(tx_exp);
      for (int k = 0; k < 500 && tx_got.size() < 53; k++) @(negedge clk);
      foreach (tx_exp[i]) chk_byte(tx_got[i], tx_exp[i]);
      for (int i = 0; i < 53; i++) begin
         @(negedge clk);
         {rxq_valid, rxq_soc, rxq_data} = {1'b1, i == 0, 8'($urandom)};
         rx_exp.push_back({~^rxq_data, rxq_soc, rxq_data});
      end
      @(negedge clk) rxq_valid = 1'b0;
      repeat (20) @(negedge clk);
      sar_u.pull(70);
      chk_reg(8'(rx_got.size()), 8'h35);
      foreach (rx_exp[i]) chk_byte(rx_got[i], rx_exp[i]);
      sar_u.reg_wr(ADDR_CTRL, 8'h02);
      repeat (20) @(negedge clk);
      chk_reg(8'(tx_full_clav), 8'h01);
      chk_reg(8'(rx_empty_clav), 8'h00);
      // Same cell in cell mode; one byte with even parity must raise bit 4.
      tx_got.delete();
      tx_exp[5].parity = ~tx_exp[5].parity;
      sar_u.send_cell(tx_exp);
      for (int k = 0; k < 500 && tx_got.size() < 53; k++) @(negedge clk);
      foreach (tx_exp[i]) chk_byte(tx_got[i], tx_exp[i]);
      sar_u.reg_rd(ADDR_STAT, rd_val);
      chk_reg(rd_val, 8'h11);
      sar_u.reg_wr(ADDR_DIAG, 8'h80);
      repeat (20) @(negedge clk);
      chk_reg(8'(tx_full_clav), 8'h00);
      close_out;
   end
endmodule : cph_host_if_bench

/* verification/cph_sar_model.sv */
// Far-side host model: register bus master plus transmit and receive driver.
// Assumes clk is the core clock and only paces the asynchronous bus.
`timescale 1ns/100ps
module cph_sar_model
   import cph_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       tx_full_clav,
   input  wire logic [7:0] ad_out,
   output logic            tx_clk,
   output logic            rx_clk,
   output logic            tx_enb_n,
   output cph_byte_t       tx_byte,
   output logic            rx_enb_n,
   output cph_ubus_t       bus_h
);
   // Link clocks free-run at 15 ns; enables idle high, bus idle.
   initial begin
      tx_clk = 1'b0;
      rx_clk = 1'b0;
      tx_enb_n = 1'b1;
      rx_enb_n = 1'b1;
      tx_byte = '0;
      bus_h = {4'h7, 8'h00};
   end
   always #7.5 tx_clk = ~tx_clk;
   always #7.5 rx_clk = ~rx_clk;

   // Each bus phase lasts 5 clk so the device's synchroniser sees it.
   task automatic step(input logic [3:0] c, input logic [7:0] a);
      repeat (5) @(negedge clk);
      bus_h = {c, a};
   endtask : step

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      step(4'hf, a);
      step(4'h7, a);
      step(4'h3, d);
      step(4'h2, d);
      step(4'h3, d);
      step(4'h7, ~d);
   endtask : reg_wr

   // Released bus shows the inverted address, never the stale address.
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      step(4'hf, a);
      step(4'h7, a);
      step(4'h3, ~a);
      step(4'h1, ~a);
      repeat (5) @(negedge clk);
      d = ad_out;
      step(4'h3, ~a);
      step(4'h7, a);
   endtask : reg_rd

   // Byte handshake: stop at once when full shows, resume on release.
   task automatic send_cell(input cph_byte_t c[$]);
      foreach (c[i]) begin
         @(negedge tx_clk);
         while (tx_full_clav !== 1'b1) begin
            tx_enb_n = 1'b1;
            @(negedge tx_clk);
         end
         tx_enb_n = 1'b0;
         tx_byte = c[i];
      end
      @(negedge tx_clk);
      tx_enb_n = 1'b1;
      tx_byte = ~tx_byte;
   endtask : send_cell

   task automatic pull(input int n);
      @(negedge rx_clk);
      rx_enb_n = 1'b0;
      repeat (n) @(negedge rx_clk);
      rx_enb_n = 1'b1;
   endtask : pull
endmodule : cph_sar_model

/* verilog/cph_cell_fifo.sv */
// Dual-clock byte store with gray pointers and registered read data.
// Assumes the writer never writes when full and the reader never reads
// when empty; both sides see their own occupancy to enforce that.
`timescale 1ns/100ps
module cph_cell_fifo #(
   parameter int W  = 10,
   parameter int AW = 7
) (
   input  wire logic          wr_clk,
   input  wire logic          wr_rst,
   input  wire logic          wr_en,
   input  wire logic [W-1:0]  wr_data,
   output logic      [AW:0]   wr_used,
   input  wire logic          rd_clk,
   input  wire logic          rd_rst,
   input  wire logic          rd_en,
   output logic      [W-1:0]  rd_data,
   output logic      [AW:0]   rd_used
);
   logic [W-1:0] mem [2**AW];
   logic [AW:0]  wr_bin_reg, wr_bin_next, wr_gray_reg, wr_gray_next;
   logic [AW:0]  rd_bin_reg, rd_bin_next, rd_gray_reg, rd_gray_next;
   logic [AW:0]  rd_gray_s, wr_gray_s;
   logic [W-1:0] rd_data_reg;

   function automatic logic [AW:0] b2g(input logic [AW:0] b);
      return (b >> 1) ^ b;
   endfunction : b2g

   function automatic logic [AW:0] g2b(input logic [AW:0] g);
      logic [AW:0] b;
      b[AW] = g[AW];
      for (int i = AW - 1; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction : g2b

   // ----------------------------------------------------------------
   // Write side
   // ----------------------------------------------------------------
   // Pointers cross as gray code so a torn sample is off by one at most.
   always_comb begin
      wr_bin_next  = wr_bin_reg + (AW+1)'(wr_en);
      wr_gray_next = b2g(wr_bin_next);
   end

   always_ff @(posedge wr_clk) begin
      if (wr_rst) begin
         wr_bin_reg  <= '0;
         wr_gray_reg <= '0;
      end else begin
         wr_bin_reg  <= wr_bin_next;
         wr_gray_reg <= wr_gray_next;
      end
   end

   // Storage has no reset; only written slots are ever read.
   always_ff @(posedge wr_clk) begin
      if (wr_en) begin
         mem[wr_bin_reg[AW-1:0]] <= wr_data;
      end
   end

   cph_sync #(.W(AW+1)) u_rd_ptr_sync (.clk(wr_clk), .d(rd_gray_reg), .q(rd_gray_s));
   assign wr_used = wr_bin_reg - g2b(rd_gray_s);

   // ----------------------------------------------------------------
   // Read side
   // ----------------------------------------------------------------
   // Read data holds its value between reads, so a stalled reader keeps it.
   always_comb begin
      rd_bin_next  = rd_bin_reg + (AW+1)'(rd_en);
      rd_gray_next = b2g(rd_bin_next);
   end

   always_ff @(posedge rd_clk) begin
      if (rd_rst) begin
         rd_bin_reg  <= '0;
         rd_gray_reg <= '0;
      end else begin
         rd_bin_reg  <= rd_bin_next;
         rd_gray_reg <= rd_gray_next;
      end
      if (rd_en) begin
         rd_data_reg <= mem[rd_bin_reg[AW-1:0]];
      end
   end

   cph_sync #(.W(AW+1)) u_wr_ptr_sync (.clk(rd_clk), .d(wr_gray_reg), .q(wr_gray_s));
   assign rd_used = g2b(wr_gray_s) - rd_bin_reg;
   assign rd_data = rd_data_reg;
endmodule : cph_cell_fifo

/* verilog/cph_host_if.sv */
// Host-facing side of a cell PHY: cell transmit and receive ports on
// host-supplied clocks, a multiplexed byte-wide register bus, interrupt.
// Assumes the register bus pins are asynchronous to clk and that the
// line logic on clk sinks transmit bytes and sources received bytes.
`timescale 1ns/100ps

// Notes on behaviour
// RULE1 - Transmit pins sampled on transmit clock, receive pins on receive clock.
// RULE2 - Control bit 1 picks byte-level or cell-level transmit handshake.
// RULE3 - Host raises transmit start-of-cell only with the first cell byte.
// RULE4 - Host drives transmit enable low only when a valid byte is present.
// RULE5 - Byte mode: full asserts while at least four more writes fit.
// RULE6 - Host drops enable within four cycles of full, waits for release.
// RULE7 - Cell mode: cell available only with room for a whole cell.
// RULE8 - Host holds enable through the last byte; may continue back to back.
// RULE9 - Receive start-of-cell is high with the first byte of a cell.
// RULE10 - Enable low in one cycle means data presented for the next cycle.
// RULE11 - Byte mode: empty indication low whenever no valid byte is shown.
// RULE12 - Cell mode: cell available only when a whole cell waits.
// RULE13 - With diagnostic bit 6, cell available may drop four bytes early.
// RULE14 - Receive path buffered by a two-cell store across clocks.
// RULE15 - Once offered, a whole cell flows, pausing only on host enable.
// RULE16 - Address taken from the shared bus when latch enable falls.
// RULE17 - Host read order: address, latch pulse, release, select, strobe.
// RULE18 - Write completes as the write strobe returns high under select.
// RULE19 - Control bit 0 clear silences the interrupt output.
// RULE20 - Control bit 5 set lets only receive cell errors interrupt.
// RULE21 - Interrupt output low while any unmasked cause is latched.
// RULE22 - Reading status returns causes, clears them, releases interrupt.
// RULE23 - Data bytes carry odd parity in both directions.
module cph_host_if
   import cph_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      reset,
   input  wire cph_ubus_t ubus,
   output logic [7:0]     ad_out,
   output logic           ad_oe,
   output logic           int_n,
   input  wire cph_evt_t  evt,
   input  wire logic      tx_clk,
   input  wire logic      tx_enb_n,
   input  wire cph_byte_t tx_byte,
   output logic           tx_full_clav,
   output cph_byte_t      txq_byte,
   output logic           txq_valid,
   input  wire logic      txq_ready,
   input  wire logic      rx_clk,
   input  wire logic      rx_enb_n,
   output cph_byte_t      rx_byte,
   output logic           rx_empty_clav,
   output logic           rx_oe,
   input  wire logic      rxq_soc,
   input  wire logic [7:0] rxq_data,
   input  wire logic      rxq_valid,
   output logic           rxq_ready
);

   // ----------------------------------------------------------------
   // Register bus, clk domain
   // ----------------------------------------------------------------
   cph_ubus_t  bus_s, bus_prev_reg;
   logic [7:0] addr_reg, addr_next, ctrl_reg, ctrl_next, diag_reg, diag_next;
   logic [7:0] status_reg, status_next, ad_out_reg, ad_out_next, evt_vec, int_mask;
   logic       ad_oe_reg, ad_oe_next, int_n_reg, int_n_next;
   logic       ale_fall, wr_rise, rd_fall, tx_par_evt, rx_ovr_evt;

   cph_sync #(.W($bits(cph_ubus_t))) u_bus_sync (.clk(clk), .d(ubus), .q(bus_s));

   // Edges are taken from the second synchroniser stage and a third copy.
   assign ale_fall = bus_prev_reg.ale && !bus_s.ale;
   assign wr_rise  = !bus_prev_reg.write_strobe_n && bus_s.write_strobe_n && !bus_s.cs_n;
   assign rd_fall  = bus_prev_reg.read_strobe_n && !bus_s.read_strobe_n && !bus_s.cs_n;

   always_comb begin
      evt_vec             = 8'h00;
      evt_vec[ST_SYMBOL]  = evt.symbol_err;
      evt_vec[ST_HEC]     = evt.hec_err;
      evt_vec[ST_SHORT]   = evt.short_cell;
      evt_vec[ST_RX_OVR]  = rx_ovr_evt;
      evt_vec[ST_TX_PAR]  = tx_par_evt;
      evt_vec[ST_LINE]    = evt.line_change;
   end

   // Register file. Read data is frozen at the strobe's falling edge so the
   // status clear cannot change a byte the host is still sampling.
   always_comb begin
      addr_next   = ale_fall ? bus_s.ad : addr_reg;                       // RULE16
      ctrl_next   = ctrl_reg;
      diag_next   = diag_reg;
      if (wr_rise && addr_reg == ADDR_CTRL) begin                         // RULE18
         ctrl_next = bus_s.ad;
      end
      if (wr_rise && addr_reg == ADDR_DIAG) begin                         // RULE18
         diag_next = bus_s.ad;
      end
      ad_out_next = ad_out_reg;
      if (rd_fall) begin
         unique case (addr_reg)
            ADDR_CTRL: ad_out_next = ctrl_reg;
            ADDR_STAT: ad_out_next = status_reg;                          // RULE22
            ADDR_DIAG: ad_out_next = diag_reg;
            default:   ad_out_next = 8'h00;
         endcase
      end
      ad_oe_next  = !bus_s.read_strobe_n && !bus_s.cs_n;                  // RULE17
      // A cause arriving in the clearing cycle survives the clear.
      status_next = status_reg;
      if (rd_fall && addr_reg == ADDR_STAT) begin
         status_next = 8'h00;                                             // RULE22
      end
      status_next = status_next | evt_vec;
      int_mask    = ctrl_next[CTRL_ERR_ONLY] ? ST_ERR_MASK : 8'hff;       // RULE20
      int_n_next  = !(ctrl_next[CTRL_INT_EN] && |(status_next & int_mask)); // RULE19 RULE21
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         bus_prev_reg <= {4'h7, 8'h00};   // Idle levels, so reset makes no false edge.
         addr_reg     <= 8'h00;
         ctrl_reg     <= CTRL_RST;
         diag_reg     <= DIAG_RST;
         status_reg   <= STAT_RST;
         ad_out_reg   <= 8'h00;
         ad_oe_reg    <= 1'b0;
         int_n_reg    <= 1'b1;
      end else begin
         bus_prev_reg <= bus_s;
         addr_reg     <= addr_next;
         ctrl_reg     <= ctrl_next;
         diag_reg     <= diag_next;
         status_reg   <= status_next;
         ad_out_reg   <= ad_out_next;
         ad_oe_reg    <= ad_oe_next;
         int_n_reg    <= int_n_next;
      end
   end

   assign ad_out = ad_out_reg;
   assign ad_oe  = ad_oe_reg;
   assign int_n  = int_n_reg;

   addr_latch_a: assert property (@(posedge clk) disable iff (reset) // RULE16
      ale_fall |=> addr_reg == $past(bus_s.ad)) else $error("address not latched");
   ctrl_write_a: assert property (@(posedge clk) disable iff (reset) // RULE18
      wr_rise && addr_reg == ADDR_CTRL |=> ctrl_reg == $past(bus_s.ad))
      else $error("control write lost");
   int_off_a: assert property (@(posedge clk) disable iff (reset) // RULE19
      !ctrl_reg[CTRL_INT_EN] |-> int_n_reg) else $error("interrupt while disabled");
   err_only_a: assert property (@(posedge clk) disable iff (reset) // RULE20
      ctrl_reg[CTRL_ERR_ONLY] && (status_reg & ST_ERR_MASK) == 8'h00 |-> int_n_reg)
      else $error("masked cause raised interrupt");
   int_fire_a: assert property (@(posedge clk) disable iff (reset) // RULE21
      ctrl_reg[CTRL_INT_EN] && !ctrl_reg[CTRL_ERR_ONLY] && status_reg != 8'h00
      |-> !int_n_reg) else $error("unmasked cause not signalled");
   read_clear_a: assert property (@(posedge clk) disable iff (reset) // RULE22
      rd_fall && addr_reg == ADDR_STAT |=> ad_out_reg == $past(status_reg)
      && status_reg == $past(evt_vec)) else $error("status read did not clear");

   // ----------------------------------------------------------------
   // Transmit port, tx_clk domain
   // ----------------------------------------------------------------
   logic [7:0] tx_used, tx_free, tx_free_n, tx_rem_n, tx_rem_reg;
   logic [5:0] tx_idx_reg, tx_idx_next;
   logic       tx_rst, tx_cell_s, tx_hold_s, tx_wr, tx_pin_next, tx_pin_reg;
   logic       tx_full_n, tx_clav;
   logic [9:0] txq_word;
   logic [7:0] txq_used;
   logic       txq_rd, txq_valid_reg, txq_valid_next, txq_load_reg;

   cph_sync #(.W(3)) u_tx_sync (.clk(tx_clk), .d({reset, ctrl_reg[CTRL_CELL],
      diag_reg[DIAG_TX_HOLD]}), .q({tx_rst, tx_cell_s, tx_hold_s}));

   // Pins are sampled straight on tx_clk; the store refuses a write when full.
   assign tx_free = FIFO_CAP - tx_used;
   assign tx_wr   = !tx_enb_n && tx_free != 8'h00 && !tx_rst;              // RULE1 RULE4

   // Flow flags look at the room left after this edge's write, so the
   // registered pin is never late.
   always_comb begin
      tx_idx_next = tx_idx_reg;
      if (tx_wr) begin
         tx_idx_next = tx_byte.soc ? 6'h01 : (tx_idx_reg == CELL_LAST ? 6'h00
                                              : tx_idx_reg + 6'h01);
      end
      tx_free_n   = tx_free - {7'h00, tx_wr};
      tx_rem_n    = tx_idx_next == 6'h00 ? 8'h00 : CELL_BYTES - {2'b00, tx_idx_next};
      tx_full_n   = !(tx_hold_s || tx_free_n <= TX_MARGIN);               // RULE5
      tx_clav     = !tx_hold_s && tx_free_n >= tx_rem_n + CELL_BYTES;      // RULE7
      tx_pin_next = tx_cell_s ? tx_clav : tx_full_n;                      // RULE2
   end

   always_ff @(posedge tx_clk) begin
      if (tx_rst) begin
         tx_idx_reg <= 6'h00;
         tx_rem_reg <= 8'h00;
         tx_pin_reg <= 1'b0;
      end else begin
         tx_idx_reg <= tx_idx_next;
         tx_rem_reg <= tx_rem_n;
         tx_pin_reg <= tx_pin_next;
      end
   end

   assign tx_full_clav = tx_pin_reg;

   tx_margin_a: assert property (@(posedge tx_clk) disable iff (tx_rst) // RULE5
      $fell(tx_pin_reg) && !tx_cell_s && !tx_hold_s |-> tx_free >= TX_MARGIN)
      else $error("full raised too late");
   tx_clav_room_a: assert property (@(posedge tx_clk) disable iff (tx_rst) // RULE7
      tx_pin_reg && tx_cell_s |-> tx_free >= tx_rem_reg + CELL_BYTES)
      else $error("cell available without room");

   cph_cell_fifo #(.W($bits(cph_byte_t)), .AW(FIFO_AW)) u_tx_fifo (
      .wr_clk  (tx_clk),
      .wr_rst  (tx_rst),
      .wr_en   (tx_wr),
      .wr_data (tx_byte),
      .wr_used (tx_used),
      .rd_clk  (clk),
      .rd_rst  (reset),
      .rd_en   (txq_rd),
      .rd_data (txq_word),
      .rd_used (txq_used)
   );

   // Line side drain; a byte that arrived with even parity is flagged.
   always_comb begin
      txq_rd         = txq_used != 8'h00 && (!txq_valid_reg || txq_ready);
      txq_valid_next = txq_rd || (txq_valid_reg && !txq_ready);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         txq_valid_reg <= 1'b0;
         txq_load_reg  <= 1'b0;
      end else begin
         txq_valid_reg <= txq_valid_next;
         txq_load_reg  <= txq_rd;
      end
   end

   assign tx_par_evt = txq_load_reg && (txq_word[9] != odd_par(txq_word[7:0])); // RULE23
   assign txq_byte   = txq_word;
   assign txq_valid  = txq_valid_reg;

   // ----------------------------------------------------------------
   // Receive port, rx_clk domain, two-cell buffer
   // ----------------------------------------------------------------
   logic [7:0] rxq_used, rx_used, rx_used_n, rx_rem_n;
   logic [5:0] rx_idx_reg, rx_idx_next;
   logic       rx_rst, rx_cell_s, rx_early_s, rx_rd, rxq_wr, rxq_ready_reg;
   logic       rx_valid_reg, rx_clav, rx_pin_next, rx_pin_reg, rx_oe_reg;
   cph_byte_t  rx_word;

   // Line side fill; ready already counts the write in this cycle.
   assign rxq_wr = rxq_valid && rxq_ready_reg;
   assign rx_ovr_evt = rxq_valid && !rxq_ready_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         rxq_ready_reg <= 1'b0;
      end else begin
         rxq_ready_reg <= rxq_used + {7'h00, rxq_wr} < FIFO_CAP;          // RULE14
      end
   end

   assign rxq_ready = rxq_ready_reg;

   cph_cell_fifo #(.W($bits(cph_byte_t)), .AW(FIFO_AW)) u_rx_fifo (
      .wr_clk  (clk),
      .wr_rst  (reset),
      .wr_en   (rxq_wr),
      .wr_data ({odd_par(rxq_data), rxq_soc, rxq_data}),                  // RULE23
      .wr_used (rxq_used),
      .rd_clk  (rx_clk),
      .rd_rst  (rx_rst),
      .rd_en   (rx_rd),
      .rd_data (rx_word),
      .rd_used (rx_used)
   );

   cph_sync #(.W(3)) u_rx_sync (.clk(rx_clk), .d({reset, ctrl_reg[CTRL_CELL],
      diag_reg[DIAG_RX_EARLY]}), .q({rx_rst, rx_cell_s, rx_early_s}));

   // Enable low at one edge fetches the byte shown in the next cycle. Cell
   // available waits for a whole cell, so the cell then flows unbroken.
   assign rx_rd = !rx_enb_n && rx_used != 8'h00 && !rx_rst;                // RULE1 RULE10 RULE15

   always_comb begin
      rx_idx_next = rx_idx_reg;
      if (rx_rd) begin
         rx_idx_next = rx_idx_reg == CELL_LAST ? 6'h00 : rx_idx_reg + 6'h01;
      end
      rx_used_n   = rx_used - {7'h00, rx_rd};
      rx_rem_n    = rx_idx_next == 6'h00 ? 8'h00 : CELL_BYTES - {2'b00, rx_idx_next};
      rx_clav     = rx_used_n >= rx_rem_n + CELL_BYTES ||                 // RULE12
                    (rx_rem_n != 8'h00 && !(rx_early_s && rx_rem_n <= RX_MARGIN)); // RULE13
      rx_pin_next = rx_cell_s ? rx_clav : rx_rd;                          // RULE11
   end

   always_ff @(posedge rx_clk) begin
      if (rx_rst) begin
         rx_idx_reg   <= 6'h00;
         rx_valid_reg <= 1'b0;
         rx_pin_reg   <= 1'b0;
         rx_oe_reg    <= 1'b0;
      end else begin
         rx_idx_reg   <= rx_idx_next;
         rx_valid_reg <= rx_rd;
         rx_pin_reg   <= rx_pin_next;
         rx_oe_reg    <= !rx_enb_n;
      end
   end

   assign rx_byte       = rx_word;                                        // RULE9
   assign rx_empty_clav = rx_pin_reg;
   assign rx_oe         = rx_oe_reg;

   rx_present_a: assert property (@(posedge rx_clk) disable iff (rx_rst) // RULE10
      !rx_enb_n && rx_used != 8'h00 |=> rx_valid_reg && (rx_cell_s || rx_pin_reg))
      else $error("enabled byte not presented");
   rx_soc_a: assert property (@(posedge rx_clk) disable iff (rx_rst) // RULE9
      rx_valid_reg && rx_byte.soc |-> rx_idx_reg == 6'h01)
      else $error("start of cell off the first byte");
   rx_clav_a: assert property (@(posedge rx_clk) disable iff (rx_rst) // RULE12
      $rose(rx_pin_reg) && rx_cell_s |-> rx_used >= CELL_BYTES)
      else $error("cell available without a cell");
   rx_parity_a: assert property (@(posedge rx_clk) disable iff (rx_rst) // RULE23
      rx_valid_reg |-> ^{rx_byte.parity, rx_byte.data} == 1'b1)
      else $error("receive parity not odd");

endmodule : cph_host_if

/* verilog/cph_sync.sv */
// Two flip-flop synchroniser for levels and gray-coded words.
// Assumes each bit may change at any time relative to clk.
`timescale 1ns/100ps
module cph_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // The first stage feeds the second stage and nothing else.
   always_ff @(posedge clk) begin
      meta_reg <= d;
      q        <= meta_reg;
   end
endmodule : cph_sync
